//--- chs_pkg.sv
// package for the charger status register block
package chs_pkg;

  // register byte addresses (printed offsets are not multiples of four)
  localparam logic [3:0] CHS_IDX_STATE  = 4'h1;
  localparam logic [3:0] CHS_IDX_INPUT  = 4'h2;
  localparam logic [3:0] CHS_IDX_IRQ_ST = 4'h3;
  localparam logic [3:0] CHS_IDX_IRQ_MK = 4'h4;
  localparam int         CHS_AW         = 6;
  localparam logic [5:0] CHS_ADDR_STATE  = 6'({CHS_IDX_STATE, 2'b00});
  localparam logic [5:0] CHS_ADDR_INPUT  = 6'({CHS_IDX_INPUT, 2'b00});
  localparam logic [5:0] CHS_ADDR_IRQ_ST = 6'({CHS_IDX_IRQ_ST, 2'b00});
  localparam logic [5:0] CHS_ADDR_IRQ_MK = 6'({CHS_IDX_IRQ_MK, 2'b00});

  // field positions of the state status register
  localparam int CHS_ZONE_LSB  = 5;
  localparam int CHS_CC1TO_BIT = 4;
  localparam int CHS_STATE_LSB = 0;

  // interrupt status and mask bit positions
  localparam int CHS_IRQ_STATE_BIT = 0;
  localparam int CHS_IRQ_CC1_BIT   = 4;
  localparam int CHS_IRQ_ZONE_BIT  = 7;

  // mask reset value and unmapped read value
  localparam logic [7:0]  CHS_MASK_RST  = 8'h00;
  localparam logic [31:0] CHS_UNMAPPED  = 32'h0000_0000;

  // thermistor zone codes
  typedef enum logic [2:0] {
    CHS_ZONE_COLD    = 3'h0,
    CHS_ZONE_COOL    = 3'h1,
    CHS_ZONE_ROOM    = 3'h2,
    CHS_ZONE_WARM    = 3'h3,
    CHS_ZONE_HOT     = 3'h4,
    CHS_ZONE_NONE    = 3'h5,
    CHS_ZONE_OFF     = 3'h6,
    CHS_ZONE_OFF_HRV = 3'h7
  } chs_zone_t;

  // charger state codes
  typedef enum logic [3:0] {
    CHS_ST_OFF      = 4'h0,
    CHS_ST_IDLE     = 4'h1,
    CHS_ST_PRE      = 4'h2,
    CHS_ST_CC1      = 4'h3,
    CHS_ST_CC2      = 4'h4,
    CHS_ST_CV       = 4'h5,
    CHS_ST_MAINT    = 4'h6,
    CHS_ST_MAINT_DN = 4'h7,
    CHS_ST_PRE_TMO  = 4'h8,
    CHS_ST_SAFE_TMO = 4'h9,
    CHS_ST_TRACK    = 4'hE,
    CHS_ST_TEMP_SUS = 4'hF
  } chs_state_t;

  // live inputs from the analog comparators and charger core
  typedef struct packed {
    logic       input_present;
    logic       charger_enabled;
    logic [1:0] charger_thermistor_enable;
    logic [1:0] harvester_thermistor_enable;
    logic [2:0] zone_raw;
    logic       first_cc_timeout;
    logic [3:0] charger_state_raw;
    logic       sys_reg;
    logic       in_volt_reg;
    logic       in_cur_lim;
    logic       overvoltage;
    logic       input_ok;
    logic       temp_shutdown;
    logic       temp_reduce;
    logic       thermal_sd;
  } chs_live_t;

endpackage

//--- chs_field_mux.sv
`timescale 1ns/1ps
// field formatting of the two live status bytes
module chs_field_mux (
  // live condition
  input  wire chs_pkg::chs_live_t live,
  // formatted bytes
  output logic [7:0]              state_byte,
  output logic [7:0]              input_byte
);
  import chs_pkg::*;

  wire       chg_off_sel;
  wire       hrv_off_sel;
  wire       mon_off;
  wire       mon_off_hrv;
  wire [2:0] zone_code;
  wire       state_rfu;
  wire [3:0] state_code;
  wire       in_qual;
  wire       chg_qual;

  assign chg_off_sel = live.charger_thermistor_enable == 2'b00;
  assign hrv_off_sel = live.harvester_thermistor_enable == 2'b00;
  assign mon_off     = (live.input_present & chg_off_sel)
                     | (~live.input_present & chg_off_sel & hrv_off_sel);
  assign mon_off_hrv = ~live.input_present & ~chg_off_sel & hrv_off_sel;
  // raw zone above the no-thermistor code is treated as absent
  assign zone_code   = mon_off     ? CHS_ZONE_OFF :
                       mon_off_hrv ? CHS_ZONE_OFF_HRV :
                       (live.zone_raw > CHS_ZONE_NONE) ? CHS_ZONE_NONE : live.zone_raw;
  // reserved codes never reach software; idle is the safe stand-in
  assign state_rfu   = (live.charger_state_raw >= 4'hA) && (live.charger_state_raw <= 4'hD);
  assign state_code  = state_rfu ? CHS_ST_IDLE : live.charger_state_raw;
  assign in_qual     = live.input_present & ~live.overvoltage & live.input_ok;
  assign chg_qual    = in_qual & live.charger_enabled;

  always_comb begin
    state_byte = 8'h00;
    state_byte[CHS_ZONE_LSB +: 3]  = zone_code;
    state_byte[CHS_CC1TO_BIT]      = live.first_cc_timeout;
    state_byte[CHS_STATE_LSB +: 4] = state_code;
    // invalid-context flags read zero so software never trusts stale analog
    input_byte = {chg_qual & live.sys_reg,
                  in_qual & live.in_volt_reg,
                  in_qual & live.in_cur_lim,
                  live.overvoltage,
                  live.input_ok,
                  chg_qual & live.temp_shutdown,
                  chg_qual & live.temp_reduce,
                  live.input_present & live.thermal_sd};
  end
endmodule

//--- chs_status_regs.sv
`timescale 1ns/1ps
// charger status registers with Avalon-MM slave and change interrupts
module chs_status_regs (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // avalon-mm slave
  input  wire logic [chs_pkg::CHS_AW-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  output logic [1:0]                       avs_response,
  // live condition from charger core
  input  wire chs_pkg::chs_live_t          live_in,
  // interrupt
  output logic                             irq
);
  import chs_pkg::*;

  chs_live_t  live_s1_q;
  chs_live_t  live_q;
  logic [7:0] state_byte;
  logic [7:0] input_byte;
  logic [7:0] prev_state_q;
  logic       prev_valid_q;
  logic [7:0] irq_st_q;
  logic [7:0] irq_st_d;
  logic [7:0] irq_mk_q;
  logic       ack_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;

  // live pins come from analog domains, so two stages first
  always_ff @(posedge clk) begin
    live_s1_q <= live_in;
    live_q    <= live_s1_q;
  end

  chs_field_mux u_fmt (
    .live       (live_q),
    .state_byte (state_byte),
    .input_byte (input_byte)
  );

  wire       req       = (avs_read | avs_write) & ~ack_q;
  wire       sel_state = avs_address == CHS_ADDR_STATE;
  wire       sel_input = avs_address == CHS_ADDR_INPUT;
  wire       sel_st    = avs_address == CHS_ADDR_IRQ_ST;
  wire       sel_mk    = avs_address == CHS_ADDR_IRQ_MK;
  wire       mapped    = sel_state | sel_input | sel_st | sel_mk;
  // write lands on the taking edge, with waitrequest low, never on the edge that ends the wait
  wire       wr_go     = ack_q & avs_write & avs_byteenable[0];
  wire [7:0] clr_mask  = (wr_go & sel_st) ? avs_writedata[7:0] : 8'h00;
  wire       zone_chg  = prev_valid_q
                       & (prev_state_q[CHS_ZONE_LSB +: 3] != state_byte[CHS_ZONE_LSB +: 3]);
  wire       code_chg  = prev_valid_q
                       & (prev_state_q[CHS_STATE_LSB +: 4] != state_byte[CHS_STATE_LSB +: 4]);
  wire       cc1_chg   = prev_valid_q
                       & (prev_state_q[CHS_CC1TO_BIT] != state_byte[CHS_CC1TO_BIT]);
  wire [7:0] ev_set;
  wire [31:0] rmux     = sel_state ? {24'h00_0000, state_byte} :
                         sel_input ? {24'h00_0000, input_byte} :
                         sel_st    ? {24'h00_0000, irq_st_q} :
                         sel_mk    ? {24'h00_0000, irq_mk_q} : CHS_UNMAPPED;

  assign ev_set = (8'h01 << CHS_IRQ_STATE_BIT) & {8{code_chg}}
                | (8'h01 << CHS_IRQ_ZONE_BIT)  & {8{zone_chg}}
                | (8'h01 << CHS_IRQ_CC1_BIT)   & {8{cc1_chg}};
  // set wins over a simultaneous write-one clear
  assign irq_st_d = (irq_st_q & ~clr_mask) | ev_set;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_state_q <= 8'h00;
      prev_valid_q <= 1'b0;
      irq_st_q     <= 8'h00;
    end else begin
      prev_state_q <= state_byte;
      prev_valid_q <= 1'b1;
      irq_st_q     <= irq_st_d;
    end
  end

  // only the mask is written here; state and input have no write path, interrupt status is write-one-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mk_q <= CHS_MASK_RST;
    end else if (wr_go & sel_mk) begin
      irq_mk_q <= avs_writedata[7:0];
    end
  end

  // one wait cycle: read data is sampled from live state
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'b00;
    end else begin
      ack_q   <= req;
      rdata_q <= (req & avs_read) ? rmux : 32'h0000_0000;
      resp_q  <= (req & ~mapped) ? 2'b11 : 2'b00;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;
  assign irq             = |(irq_st_q & irq_mk_q);
endmodule

//--- chs_status_regs_assertions.sv
// port assertions for the charger status register block
`timescale 1ns/1ps
module chs_status_regs_assertions (
  // clock, reset and bus
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [chs_pkg::CHS_AW-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic [1:0]                 avs_response,
  // live condition
  input wire chs_pkg::chs_live_t         live_in
);
  import chs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_st = avs_read && !avs_waitrequest && avs_address == CHS_ADDR_STATE;
  wire rd_in = avs_read && !avs_waitrequest && avs_address == CHS_ADDR_INPUT;
  // sync latency needs a few quiet cycles before a read can mirror live
  sequence quiet_s; $stable(live_in)[*4]; endsequence
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
  a_wait_idle: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest) else $error("stray wait");
  a_unmapped_resp: assert property (
    avs_read && avs_waitrequest && avs_address > 6'h10 |=>
    avs_response == 2'h3 && avs_readdata == 32'h0000_0000) else $error("unmapped answer");
  a_data_release: assert property (
    avs_read && !avs_waitrequest |=> avs_readdata == 32'h0000_0000) else $error("data stays");
  a_state_legal: assert property (
    rd_st |-> !(avs_readdata[3:0] inside {[4'hA:4'hD]})) else $error("reserved code");
  a_flag_qual: assert property (
    rd_in && |avs_readdata[7:5] |-> avs_readdata[4:3] == 2'h1) else $error("flag unqualified");
  a_live_input: assert property (
    quiet_s ##1 rd_in
    |-> avs_readdata[4:3] == {$past(live_in.overvoltage, 3), $past(live_in.input_ok, 3)})
    else $error("input bits wrong");
  a_zone_off: assert property (
    quiet_s ##1 rd_st && $past(live_in.input_present, 3)
    && $past(live_in.charger_thermistor_enable, 3) == 2'h0
    |-> avs_readdata[7:5] == 3'h6) else $error("zone not off");
  c_read_state: cover property (rd_st);
  c_read_input: cover property (rd_in);
  c_unmapped: cover property (avs_read && avs_response == 2'h3);
endmodule
bind chs_status_regs chs_status_regs_assertions u_chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .live_in(live_in));

//--- chs_status_regs_tb.sv
// self-checking bench for the charger status register block
`timescale 1ns/1ps
module chs_status_regs_tb;
  import chs_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, irq;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [1:0]  avs_response, rs;
  logic        avs_waitrequest;
  chs_live_t   live_in = '0;
  int          n_fail = 0, checked = 0;
  // live condition, expected state byte, expected input byte
  logic [37:0] rows [7] = '{
    {1'h1, 1'h1, 2'h1, 2'h0, 3'h2, 1'h1, 4'h3, 8'hFF, 8'h53, 8'h19},
    {1'h1, 1'h1, 2'h1, 2'h0, 3'h4, 1'h0, 4'h5, 8'hEF, 8'h85, 8'hEF},
    {1'h1, 1'h0, 2'h1, 2'h0, 3'h0, 1'h0, 4'h9, 8'hEF, 8'h09, 8'h69},
    {1'h1, 1'h1, 2'h0, 2'h0, 3'h1, 1'h1, 4'hA, 8'hF7, 8'hD1, 8'h11},
    {1'h0, 1'h1, 2'h0, 2'h0, 3'h1, 1'h0, 4'h8, 8'hFF, 8'hC8, 8'h18},
    {1'h0, 1'h1, 2'h2, 2'h0, 3'h1, 1'h0, 4'hE, 8'h00, 8'hEE, 8'h00},
    {1'h0, 1'h1, 2'h0, 2'h3, 3'h3, 1'h0, 4'h1, 8'h00, 8'h61, 8'h00}};
  chs_status_regs u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .live_in(live_in), .irq(irq));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until waitrequest is seen low, released at that same edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    // values read right after the edge are the ones that edge sampled
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string what);
    bus(1'b0, a, 8'h00, 4'h0);
    chk(what, rd, {24'h00_0000, e});
  endtask
  // two sync flops plus the read register, so four quiet cycles suffice
  task automatic setl(input chs_live_t v);
    @(posedge clk);
    live_in <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic irqc(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(CHS_ADDR_IRQ_MK, 8'h00, "mask reset");
    irqc(1'b0);
    for (int i = 0; i < 7; i++) begin
      setl(rows[i][37:16]);
      rdc(CHS_ADDR_STATE, rows[i][15:8], "state byte");
      rdc(CHS_ADDR_INPUT, rows[i][7:0], "input byte");
    end
    for (int k = 0; k < 16; k++) begin
      setl({1'h1, 1'h1, 2'h1, 2'h0, k[2:0], 1'h0, k[3:0], 8'h00});
      rdc(CHS_ADDR_STATE, {(k[2:0] > 3'h5) ? 3'h5 : k[2:0], 1'h0,
          (k >= 10 && k <= 13) ? 4'h1 : k[3:0]}, "codes");
    end
    bus(1'b1, CHS_ADDR_IRQ_ST, 8'hFF, 4'h1);
    rdc(CHS_ADDR_IRQ_ST, 8'h00, "irq cleared");
    bus(1'b1, CHS_ADDR_IRQ_MK, 8'h01, 4'h1);
    setl({1'h1, 1'h1, 2'h1, 2'h0, 3'h7, 1'h0, 4'h2, 8'h00});
    irqc(1'b1);
    rdc(CHS_ADDR_IRQ_ST, 8'h01, "state event");
    bus(1'b1, CHS_ADDR_IRQ_ST, 8'h01, 4'h1);
    irqc(1'b0);
    setl({1'h1, 1'h1, 2'h1, 2'h0, 3'h0, 1'h1, 4'h2, 8'h00});
    irqc(1'b0);
    rdc(CHS_ADDR_IRQ_ST, 8'h90, "masked events");
    bus(1'b1, CHS_ADDR_STATE, 8'hFF, 4'h1);
    rdc(CHS_ADDR_STATE, 8'h12, "write ignored");
    chk("okay resp", {30'h0, rs}, 32'h0000_0000);
    bus(1'b1, CHS_ADDR_IRQ_MK, 8'hFF, 4'h0);
    rdc(CHS_ADDR_IRQ_MK, 8'h01, "lane off");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(CHS_ADDR_IRQ_MK, 8'h00, "mask after reset");
    rdc(CHS_ADDR_IRQ_ST, 8'h00, "status after reset");
    irqc(1'b0);
    rdc(CHS_ADDR_STATE, 8'h12, "live after reset");
    rdc(6'h3C, 8'h00, "unmapped data");
    chk("unmapped resp", {30'h0, rs}, 32'h0000_0003);
    print_verdict();
  end
endmodule
